// ==== hdl/cpm_pkg.sv ====
// package for the clock power monitor register bank: offsets, field positions, reset values, carrier types
// assumes a serial port engine outside that turns bus frames into byte reads and writes
package cpm_pkg;
   localparam logic [15:0] OFS_XTAL_DBL   = 16'h00B4;
   localparam logic [15:0] OFS_REF_PWR    = 16'h00B5;
   localparam logic [15:0] OFS_OUT_PWR    = 16'h00B7;
   localparam logic [15:0] OFS_LOOP_PWR   = 16'h00B8;
   localparam logic [15:0] OFS_REF0_TOP   = 16'h00B9;
   localparam logic [15:0] OFS_REF0_MID   = 16'h00BA;
   localparam logic [15:0] OFS_REF0_LOW   = 16'h00BB;
   localparam logic [15:0] OFS_REF1_TOP   = 16'h00BC;
   localparam logic [15:0] OFS_REF1_MID   = 16'h00BD;
   localparam logic [15:0] OFS_REF1_LOW   = 16'h00BE;
   localparam logic [15:0] OFS_IRQ_EN     = 16'h00C7;
   localparam logic [15:0] OFS_IRQ_STAT   = 16'h0200;

   localparam int BIT_DBL_BYPASS = 0;
   localparam int BIT_LOOP_DIS   = 2;
   localparam int BIT_CAL_RST    = 0;
   localparam int BIT_LOCK_LOSS  = 6;
   localparam int BIT_HOLDOVER   = 4;
   localparam int BIT_REF1_LOSS  = 1;
   localparam int BIT_REF0_LOSS  = 0;

   localparam int          THR_W     = 17;
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [16:0] THR_RST   = 17'h00003;
   localparam logic [7:0]  EVT_MASK  = 8'h53;

   typedef struct packed {
      logic       crystal_doubler_bypass;
      logic [1:0] ref_input_disable;
      logic [7:0] output_disable;
      logic       digital_loop_disable;
      logic       analog_loop_cal_reset;
   } cpm_ctrl_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } cpm_req_t;
endpackage

// ==== hdl/cpm_regs.sv ====
// register bank with power-down controls, reference loss monitors and the alarm interrupt
// assumes the serial port engine issues one-cycle byte strobes synchronous to ref_clk_i
// Overview of operation
// - bypass bit 0 feeds the loop twice the crystal frequency, bit 1 feeds the crystal frequency as is.
// - each input reference has a disable bit, 1 disables it and 0 keeps it running.
// - each of the eight outputs has a disable bit that stops its logic and floats its driver when 1.
// - the digital loop is stopped while its disable bit is 1 and runs while it is 0.
// - the analog loop calibration logic is held in reset while its reset bit is 1.
// - each reference has a 17-bit threshold of monitor periods after which a missing reference is a soft loss.
// - the lock loss flag reaches the interrupt only while its enable bit is 1.
// - the holdover flag reaches the interrupt only while its enable bit is 1.
// - each reference loss flag reaches the interrupt only while its own enable bit is 1.
// - all disable and interrupt enable bits reset to 0.
// - every alarm sets a sticky flag that stays until the host writes 1 to it.
module cpm_regs #(
   parameter logic [16:0] THR_RESET = cpm_pkg::THR_RST
) (
   input  wire logic               ref_clk_i,
   input  wire logic               reset_i,
   input  wire cpm_pkg::cpm_req_t  req_i,
   output logic [7:0]              rd_data_o,
   input  wire logic               monitor_tick_i,
   input  wire logic [1:0]         ref_edge_i,
   input  wire logic               lock_loss_i,
   input  wire logic               holdover_i,
   output cpm_pkg::cpm_ctrl_t      ctrl_o,
   output logic [7:0]              output_drive_en_o,
   output logic [1:0]              ref_loss_o,
   output logic                    irq_n_out_o
);
   logic [7:0]  dbl_r, refp_r, outp_r, loopp_r, irq_en_r, flag_r, rd_data_r;
   logic [16:0] thr_r [2];
   logic [16:0] cnt_r [2];
   logic [1:0]  loss_r;
   logic        irq_n_r;

   wire wr_dbl   = req_i.wr && req_i.addr == cpm_pkg::OFS_XTAL_DBL;
   wire wr_refp  = req_i.wr && req_i.addr == cpm_pkg::OFS_REF_PWR;
   wire wr_outp  = req_i.wr && req_i.addr == cpm_pkg::OFS_OUT_PWR;
   wire wr_loopp = req_i.wr && req_i.addr == cpm_pkg::OFS_LOOP_PWR;
   wire wr_en    = req_i.wr && req_i.addr == cpm_pkg::OFS_IRQ_EN;
   wire wr_stat  = req_i.wr && req_i.addr == cpm_pkg::OFS_IRQ_STAT;

   // alarm events in status bit layout
   wire [7:0] evt = {1'b0, lock_loss_i, 1'b0, holdover_i, 2'b00, loss_r} & cpm_pkg::EVT_MASK;
   wire [7:0] clr = wr_stat ? req_i.wdata : 8'h00;
   // set beats clear so an alarm during the clearing write is kept
   wire [7:0] flag_nxt = (flag_r & ~clr) | evt;
   // masking per source
   wire       irq_nxt = |(flag_r & irq_en_r & cpm_pkg::EVT_MASK);

   // only the documented bits are stored, so reserved bits read as zero whatever is written
   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) begin
         dbl_r    <= cpm_pkg::CTRL_RST;
         refp_r   <= cpm_pkg::CTRL_RST;
         outp_r   <= cpm_pkg::CTRL_RST;
         loopp_r  <= cpm_pkg::CTRL_RST;
         irq_en_r <= cpm_pkg::CTRL_RST;
         flag_r   <= 8'h00;
         irq_n_r  <= 1'b1;
      end else begin
         if (wr_dbl)   dbl_r    <= req_i.wdata & 8'h01;
         if (wr_refp)  refp_r   <= req_i.wdata & 8'h03;
         if (wr_outp)  outp_r   <= req_i.wdata;
         if (wr_loopp) loopp_r  <= req_i.wdata & 8'h05;
         if (wr_en)    irq_en_r <= req_i.wdata & cpm_pkg::EVT_MASK;
         flag_r  <= flag_nxt;
         irq_n_r <= ~irq_nxt;
      end
   end

   // per-reference threshold and missing-reference counter
   for (genvar g = 0; g < 2; g++) begin : g_mon
      localparam logic [15:0] TOP = g == 0 ? cpm_pkg::OFS_REF0_TOP : cpm_pkg::OFS_REF1_TOP;
      localparam logic [15:0] MID = g == 0 ? cpm_pkg::OFS_REF0_MID : cpm_pkg::OFS_REF1_MID;
      localparam logic [15:0] LOW = g == 0 ? cpm_pkg::OFS_REF0_LOW : cpm_pkg::OFS_REF1_LOW;
      wire wr_top = req_i.wr && req_i.addr == TOP;
      wire wr_mid = req_i.wr && req_i.addr == MID;
      wire wr_low = req_i.wr && req_i.addr == LOW;
      // a disabled reference is not watched, so it raises no loss alarm
      wire watch  = !refp_r[g];
      wire hit    = watch && monitor_tick_i && !ref_edge_i[g] && (cnt_r[g] + 17'h00001 >= thr_r[g]);
      always_ff @(posedge ref_clk_i or posedge reset_i) begin
         if (reset_i) begin
            thr_r[g]  <= THR_RESET;
            cnt_r[g]  <= 17'h00000;
            loss_r[g] <= 1'b0;
         end else begin
            if (wr_top) thr_r[g][16] <= req_i.wdata[0];
            if (wr_mid) thr_r[g][15:8] <= req_i.wdata;
            if (wr_low) thr_r[g][7:0] <= req_i.wdata;
            if (!watch || ref_edge_i[g]) begin
               cnt_r[g]  <= 17'h00000;
               loss_r[g] <= 1'b0;
            end else if (monitor_tick_i && !hit) begin
               cnt_r[g] <= cnt_r[g] + 17'h00001;
            end else if (hit) begin
               loss_r[g] <= 1'b1;
            end
         end
      end
   end

   wire [7:0] rd_mux =
      req_i.addr == cpm_pkg::OFS_XTAL_DBL ? dbl_r :
      req_i.addr == cpm_pkg::OFS_REF_PWR  ? refp_r :
      req_i.addr == cpm_pkg::OFS_OUT_PWR  ? outp_r :
      req_i.addr == cpm_pkg::OFS_LOOP_PWR ? loopp_r :
      req_i.addr == cpm_pkg::OFS_REF0_TOP ? {7'h00, thr_r[0][16]} :
      req_i.addr == cpm_pkg::OFS_REF0_MID ? thr_r[0][15:8] :
      req_i.addr == cpm_pkg::OFS_REF0_LOW ? thr_r[0][7:0] :
      req_i.addr == cpm_pkg::OFS_REF1_TOP ? {7'h00, thr_r[1][16]} :
      req_i.addr == cpm_pkg::OFS_REF1_MID ? thr_r[1][15:8] :
      req_i.addr == cpm_pkg::OFS_REF1_LOW ? thr_r[1][7:0] :
      req_i.addr == cpm_pkg::OFS_IRQ_EN   ? irq_en_r :
      req_i.addr == cpm_pkg::OFS_IRQ_STAT ? flag_r : 8'h00;

   always_ff @(posedge ref_clk_i or posedge reset_i) begin
      if (reset_i) rd_data_r <= 8'h00;
      else if (req_i.rd) rd_data_r <= rd_mux;
   end

   assign rd_data_o                   = rd_data_r;
   assign ctrl_o.crystal_doubler_bypass = dbl_r[cpm_pkg::BIT_DBL_BYPASS];
   assign ctrl_o.ref_input_disable    = refp_r[1:0];
   assign ctrl_o.output_disable       = outp_r;
   assign ctrl_o.digital_loop_disable = loopp_r[cpm_pkg::BIT_LOOP_DIS];
   assign ctrl_o.analog_loop_cal_reset = loopp_r[cpm_pkg::BIT_CAL_RST];
   assign output_drive_en_o           = ~outp_r;
   assign ref_loss_o                  = loss_r;
   assign irq_n_out_o                 = irq_n_r;

   // assertions
   sequence s_clear_lock;
      wr_stat && req_i.wdata[cpm_pkg::BIT_LOCK_LOSS] && !lock_loss_i;
   endsequence

   a_lock_masked: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      flag_r[cpm_pkg::BIT_LOCK_LOSS] && !irq_en_r[cpm_pkg::BIT_LOCK_LOSS] &&
      (flag_r & irq_en_r) == 8'h00 |=> irq_n_out_o)
      else $error("masked lock loss drove interrupt");
   a_hold_masked: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      flag_r[cpm_pkg::BIT_HOLDOVER] && !irq_en_r[cpm_pkg::BIT_HOLDOVER] &&
      (flag_r & irq_en_r) == 8'h00 |=> irq_n_out_o)
      else $error("masked holdover drove interrupt");
   a_loss_enabled: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_en_r[cpm_pkg::BIT_REF0_LOSS] && flag_r[cpm_pkg::BIT_REF0_LOSS] |=> !irq_n_out_o)
      else $error("enabled reference loss missed interrupt");
   a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      irq_n_out_o == !$past(|(flag_r & irq_en_r)))
      else $error("interrupt level wrong");
   a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      flag_r[cpm_pkg::BIT_HOLDOVER] && !(wr_stat && req_i.wdata[cpm_pkg::BIT_HOLDOVER])
      |=> flag_r[cpm_pkg::BIT_HOLDOVER])
      else $error("sticky flag lost");
   a_flag_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      s_clear_lock |=> !flag_r[cpm_pkg::BIT_LOCK_LOSS])
      else $error("write one did not clear");
   a_set_wins: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      lock_loss_i |=> flag_r[cpm_pkg::BIT_LOCK_LOSS])
      else $error("alarm lost against clear");
   a_loss_count: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(loss_r[0]) |-> $past(cnt_r[0]) + 17'h00001 >= $past(thr_r[0]) && !$past(refp_r[0]))
      else $error("loss raised before threshold");
   a_ref_disable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      refp_r[1] |=> !loss_r[1])
      else $error("disabled reference raised loss");
   a_out_hiz: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      wr_outp |=> output_drive_en_o == ~$past(req_i.wdata))
      else $error("output drive enable wrong");
   a_reset_ctrl: assert property (@(posedge ref_clk_i)
      $fell(reset_i) |-> ctrl_o == '0 && irq_en_r == 8'h00)
      else $error("controls not zero after reset");
   a_loop_bits: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      wr_loopp |=> ctrl_o.digital_loop_disable == $past(req_i.wdata[2]) &&
                   ctrl_o.analog_loop_cal_reset == $past(req_i.wdata[0]))
      else $error("loop control bits wrong");
   a_dbl_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      wr_dbl |=> ctrl_o.crystal_doubler_bypass == $past(req_i.wdata[0]))
      else $error("doubler bypass wrong");

   // loss path: threshold hit, alarm level on the next edge, sticky flag one edge later
   sequence s_ref0_hit;
      !refp_r[0] && monitor_tick_i && !ref_edge_i[0] && cnt_r[0] + 17'h00001 >= thr_r[0];
   endsequence

   sequence s_ref0_raised;
      loss_r[0] ##1 flag_r[cpm_pkg::BIT_REF0_LOSS];
   endsequence

   a_loss_raise: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      s_ref0_hit |=> s_ref0_raised)
      else $error("reference loss not raised and flagged");
   a_loss_tick: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      $rose(loss_r[1]) |-> $past(monitor_tick_i) && !$past(ref_edge_i[1]) && !$past(refp_r[1]))
      else $error("loss raised without a silent monitor tick");
   a_loss_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      ref_edge_i[1] |=> !loss_r[1] && cnt_r[1] == 17'h00000)
      else $error("reference activity did not clear loss");
   a_thr_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      req_i.wr && req_i.addr == cpm_pkg::OFS_REF0_LOW |=> thr_r[0][7:0] == $past(req_i.wdata))
      else $error("threshold low byte not stored");
   a_ref0_disable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      refp_r[0] |=> !loss_r[0])
      else $error("disabled reference raised loss");
   a_hold_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      holdover_i |=> flag_r[cpm_pkg::BIT_HOLDOVER])
      else $error("holdover alarm not flagged");
   a_ref_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      loss_r[1] |=> flag_r[cpm_pkg::BIT_REF1_LOSS])
      else $error("reference loss not flagged");
   a_rd_flags: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      req_i.rd && req_i.addr == cpm_pkg::OFS_IRQ_STAT |=> rd_data_o == $past(flag_r))
      else $error("status read wrong");
   a_out_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
      !wr_outp |=> $stable(output_drive_en_o))
      else $error("output drive enable changed without a write");
   a_reset_state: assert property (@(posedge ref_clk_i)
      $fell(reset_i) |-> flag_r == 8'h00 && irq_n_out_o && output_drive_en_o == 8'hFF &&
                         thr_r[0] == THR_RESET && thr_r[1] == THR_RESET)
      else $error("state not at reset values after reset");
endmodule

// ==== dv/cpm_host_model.sv ====
// host model: issues byte reads and writes on the register port
// assumes one request at a time, launched and released on the falling edge
module cpm_host_model (
   input  wire logic              ref_clk_i,
   output cpm_pkg::cpm_req_t      req_o,
   input  wire logic [7:0]        rd_data_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req_o = '0;
   // callers pass reserved bits as zero and thresholds of 3 or more
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk_i);
      req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge ref_clk_i);
      req_o.wr = 1'b0;
   endtask
   // data is taken at the falling edge after the strobe's rising edge, where it has settled
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(negedge ref_clk_i);
      req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge ref_clk_i);
      req_o.rd = 1'b0;
      d = rd_data_i;
   endtask
endmodule

// ==== dv/cpm_regs_tb.sv ====
// testbench for the register bank: host model calls with expected values
// assumes a 25 MHz clock and inputs changed on the falling edge
module cpm_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic               ref_clk_i, reset_i, monitor_tick_i, lock_loss_i, holdover_i, irq_n_out_o;
   logic [1:0]         ref_edge_i, ref_loss_o;
   logic [7:0]         rd_data_o, output_drive_en_o;
   cpm_pkg::cpm_req_t  req_i;
   cpm_pkg::cpm_ctrl_t ctrl_o;
   int                 fail_count = 0;
   int                 samples_checked = 0;
   logic [15:0]        ofs [5] = '{16'h00B4, 16'h00B5, 16'h00B7, 16'h00B8, 16'h00C7};
   cpm_regs cpm_regs_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .req_i(req_i), .rd_data_o(rd_data_o),
      .monitor_tick_i(monitor_tick_i), .ref_edge_i(ref_edge_i), .lock_loss_i(lock_loss_i),
      .holdover_i(holdover_i), .ctrl_o(ctrl_o), .output_drive_en_o(output_drive_en_o),
      .ref_loss_o(ref_loss_o), .irq_n_out_o(irq_n_out_o));
   cpm_host_model cpm_host_model_inst (.ref_clk_i(ref_clk_i), .req_o(req_i), .rd_data_i(rd_data_o));
   initial begin
      ref_clk_i = 1'b0;
      forever #20 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      cpm_host_model_inst.rd(a, d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      cpm_host_model_inst.wr(a, d);
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #(40 * 3000);
      fail_count++;
      stop_test();
   end
   initial begin
      {reset_i, monitor_tick_i, lock_loss_i, holdover_i, ref_edge_i} = 6'h20;
      idle(16);
      reset_i = 1'b0;
      foreach (ofs[i]) rchk(ofs[i], 8'h00);
      rchk(cpm_pkg::OFS_REF0_LOW, 8'h03);
      chk(output_drive_en_o, 8'hFF);
      chk({7'h00, irq_n_out_o}, 8'h01);
      $display("test reset values done");
      wr(cpm_pkg::OFS_XTAL_DBL, 8'h01);
      chk({7'h00, ctrl_o.crystal_doubler_bypass}, 8'h01);
      wr(cpm_pkg::OFS_REF_PWR, 8'h03);
      chk({6'h00, ctrl_o.ref_input_disable}, 8'h03);
      wr(cpm_pkg::OFS_OUT_PWR, 8'hA5);
      chk(output_drive_en_o, 8'h5A);
      chk(ctrl_o.output_disable, 8'hA5);
      wr(cpm_pkg::OFS_LOOP_PWR, 8'h05);
      chk({6'h00, ctrl_o.digital_loop_disable, ctrl_o.analog_loop_cal_reset}, 8'h03);
      rchk(cpm_pkg::OFS_LOOP_PWR, 8'h05);
      wr(cpm_pkg::OFS_LOOP_PWR, 8'h01);
      chk({6'h00, ctrl_o.digital_loop_disable, ctrl_o.analog_loop_cal_reset}, 8'h01);
      wr(cpm_pkg::OFS_XTAL_DBL, 8'h00);
      chk({7'h00, ctrl_o.crystal_doubler_bypass}, 8'h00);
      wr(16'h00B6, 8'h00);
      rchk(16'h00B6, 8'h00);
      wr(cpm_pkg::OFS_REF_PWR, 8'h00);
      chk({6'h00, ctrl_o.ref_input_disable}, 8'h00);
      $display("test control bits done");
      wr(cpm_pkg::OFS_REF0_LOW, 8'h05);
      monitor_tick_i = 1'b1;
      idle(4);
      monitor_tick_i = 1'b0;
      idle(3);
      chk({6'h00, ref_loss_o}, 8'h02);
      monitor_tick_i = 1'b1;
      idle(1);
      monitor_tick_i = 1'b0;
      idle(3);
      chk({6'h00, ref_loss_o}, 8'h03);
      rchk(cpm_pkg::OFS_IRQ_STAT, 8'h03);
      chk({7'h00, irq_n_out_o}, 8'h01);
      wr(cpm_pkg::OFS_IRQ_EN, 8'h01);
      idle(2);
      chk({7'h00, irq_n_out_o}, 8'h00);
      wr(cpm_pkg::OFS_REF_PWR, 8'h02);
      idle(1);
      chk({6'h00, ref_loss_o}, 8'h01);
      wr(cpm_pkg::OFS_REF_PWR, 8'h00);
      ref_edge_i = 2'h3;
      idle(1);
      ref_edge_i = 2'h0;
      idle(2);
      chk({6'h00, ref_loss_o}, 8'h00);
      rchk(cpm_pkg::OFS_IRQ_STAT, 8'h03);
      wr(cpm_pkg::OFS_IRQ_STAT, 8'h01);
      idle(2);
      rchk(cpm_pkg::OFS_IRQ_STAT, 8'h02);
      chk({7'h00, irq_n_out_o}, 8'h01);
      $display("test reference loss done");
      lock_loss_i = 1'b1;
      idle(1);
      lock_loss_i = 1'b0;
      idle(3);
      chk({7'h00, irq_n_out_o}, 8'h01);
      wr(cpm_pkg::OFS_IRQ_EN, 8'h40);
      idle(2);
      chk({7'h00, irq_n_out_o}, 8'h00);
      holdover_i = 1'b1;
      idle(1);
      holdover_i = 1'b0;
      wr(cpm_pkg::OFS_IRQ_EN, 8'h50);
      wr(cpm_pkg::OFS_IRQ_STAT, 8'h40);
      idle(2);
      chk({7'h00, irq_n_out_o}, 8'h00);
      wr(cpm_pkg::OFS_IRQ_EN, 8'h40);
      idle(2);
      chk({7'h00, irq_n_out_o}, 8'h01);
      wr(cpm_pkg::OFS_IRQ_STAT, 8'h13);
      rchk(cpm_pkg::OFS_IRQ_STAT, 8'h00);
      $display("test alarm flags done");
      reset_i = 1'b1;
      idle(2);
      reset_i = 1'b0;
      chk(output_drive_en_o, 8'hFF);
      rchk(cpm_pkg::OFS_OUT_PWR, 8'h00);
      rchk(cpm_pkg::OFS_LOOP_PWR, 8'h00);
      rchk(cpm_pkg::OFS_REF0_LOW, 8'h03);
      rchk(cpm_pkg::OFS_IRQ_EN, 8'h00);
      $display("test mid-run reset done");
      stop_test();
   end
endmodule
